//--- opdec_pkg.sv
// Package of opcode map constants for the nibble core decoder
package opdec_pkg;
  localparam int unsigned WORD_W = 10;
  localparam int unsigned COL_W = 6;
  localparam int unsigned ROW_W = 4;
  localparam int unsigned NIB_W = 4;
  localparam logic [3:0] NIB_RESET = 4'h0;
  // First-word opcodes (column, row) packed as 10-bit words
  localparam logic [9:0] OP_NO_OPERATION = 10'h000;
  localparam logic [9:0] OP_SOFTWARE_SYSTEM_RESET = 10'h001;
  localparam logic [9:0] OP_ENTER_CLOCK_OPERATING = 10'h002;
  localparam logic [9:0] OP_SKIP_ON_POWERDOWN_FLAG = 10'h003;
  localparam logic [9:0] OP_ENTER_RAM_BACKUP = 10'h008;
  localparam logic [9:0] OP_SKIP_EQUAL_IMMEDIATE = 10'h025;
  localparam logic [9:0] OP_SKIP_PORT_BIT_ZERO = 10'h024;
  localparam logic [9:0] OP_CLEAR_HIGH_REF = 10'h058;
  localparam logic [9:0] OP_SET_HIGH_REF = 10'h059;
  localparam logic [9:0] OP_ARM_POWER_DOWN = 10'h05B;
  localparam logic [9:0] OP_WRITE_CLOCK_RANGE = 10'h209;
  localparam logic [9:0] OP_WRITE_LCD_CTRL_ONE = 10'h20A;
  localparam logic [9:0] OP_WRITE_LCD_CTRL_TWO = 10'h20B;
  localparam logic [9:0] OP_WRITE_LCD_CTRL_THREE = 10'h20C;
  localparam logic [9:0] OP_WRITE_CLOCK_MODE = 10'h216;
  localparam logic [9:0] OP_READ_LCD_CTRL_ONE = 10'h24A;
  localparam logic [9:0] OP_READ_CLOCK_MODE = 10'h252;
  localparam logic [9:0] OP_ENABLE_VOLTAGE_DROP = 10'h293;
  localparam logic [9:0] OP_SELECT_RC_OSC = 10'h29B;
  localparam logic [9:0] OP_WATCHDOG_DISABLE_PREP = 10'h29C;
  localparam logic [9:0] OP_WATCHDOG_SERVICE = 10'h2A0;
  localparam logic [9:0] OP_WRITE_LCD_CFG_ONE = 10'h2A8;
  localparam logic [9:0] OP_WRITE_LCD_CFG_TWO = 10'h2A9;
  // Two-word first-word columns
  localparam logic [5:0] COL_INDIRECT_PAGE_JUMP = 6'h01;
  localparam logic [5:0] COL_INDIRECT_PAGE_CALL = 6'h03;
  localparam logic [5:0] COL_LONG_CALL_LO = 6'h0C;
  localparam logic [5:0] COL_LONG_CALL_HI = 6'h0D;
  localparam logic [5:0] COL_LONG_JUMP_LO = 6'h0E;
  localparam logic [5:0] COL_LONG_JUMP_HI = 6'h0F;
  localparam logic [3:0] ROW_ZERO = 4'h0;
  // Second-word fields
  localparam int unsigned SW_TOP = 9;
  localparam int unsigned SW_PAGE_HI = 8;
  localparam int unsigned SW_PAGE_LO = 7;
  localparam logic [1:0] SW_IND_ZERO = 2'h0;
  localparam logic [5:0] SW_SEA_PREFIX = 6'h07;
  localparam logic [9:0] SW_SZD_FIXED = 10'h02B;
  typedef enum logic [2:0]
  {
    K_NONE = 3'h0,
    K_LONG_JUMP = 3'h1,
    K_LONG_CALL = 3'h2,
    K_IND_JUMP = 3'h3,
    K_IND_CALL = 3'h4,
    K_SEA = 3'h5,
    K_SZD = 3'h6
  } twoword_e;
endpackage

//--- word_bus_if.sv
// Interface carrying a fetched word and its split fields between modules
`timescale 1ns/1ns
interface word_bus_if;
  logic [9:0] word;
  logic [5:0] col;
  logic [3:0] row;
  logic [2:0] two_kind;
  modport splitter
  (
    input word,
    output col,
    output row,
    output two_kind
  );
  modport user
  (
    output word,
    input col,
    input row,
    input two_kind
  );
endinterface

//--- opdec_split.sv
// Splits an instruction word into map column, row and two-word class
`timescale 1ns/1ns
module opdec_split
(
  word_bus_if.splitter wb
);
  always_comb
  begin
    wb.col = wb.word[9:4];
    wb.row = wb.word[3:0];
    wb.two_kind = opdec_pkg::K_NONE;
    // Two-word detection from the first word alone
    if (wb.col == opdec_pkg::COL_LONG_JUMP_LO || wb.col == opdec_pkg::COL_LONG_JUMP_HI)
    begin
      wb.two_kind = opdec_pkg::K_LONG_JUMP;
    end
    else if (wb.col == opdec_pkg::COL_LONG_CALL_LO || wb.col == opdec_pkg::COL_LONG_CALL_HI)
    begin
      wb.two_kind = opdec_pkg::K_LONG_CALL;
    end
    else if (wb.col == opdec_pkg::COL_INDIRECT_PAGE_JUMP && wb.row == opdec_pkg::ROW_ZERO)
    begin
      wb.two_kind = opdec_pkg::K_IND_JUMP;
    end
    else if (wb.col == opdec_pkg::COL_INDIRECT_PAGE_CALL && wb.row == opdec_pkg::ROW_ZERO)
    begin
      wb.two_kind = opdec_pkg::K_IND_CALL;
    end
    else if (wb.word == opdec_pkg::OP_SKIP_EQUAL_IMMEDIATE)
    begin
      wb.two_kind = opdec_pkg::K_SEA;
    end
    else if (wb.word == opdec_pkg::OP_SKIP_PORT_BIT_ZERO)
    begin
      wb.two_kind = opdec_pkg::K_SZD;
    end
  end
endmodule

//--- opdec_core.sv
// Instruction decoder for system, clock and LCD control instructions
`timescale 1ns/1ns
module opdec_core
#(
  parameter bit HAS_VDET = 1'b1
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic word_valid,
  input wire logic [9:0] word_in,
  input wire logic [3:0] acc_in,
  input wire logic powerdown_flag,
  input wire logic watchdog_flag_first,
  output logic exec_q,
  output logic skipped_q,
  output logic operand_q,
  output logic pc_advance_q,
  output logic system_reset_q,
  output logic enter_clock_operating_mode_q,
  output logic enter_ram_backup_mode_q,
  output logic watchdog_flag_clear_q,
  output logic watchdog_stop_q,
  output logic high_ref_enable_flag_q,
  output logic voltage_drop_detect_en_q,
  output logic rc_osc_selected_q,
  output logic onchip_osc_stop_q,
  output logic acc_load_q,
  output logic [3:0] acc_out_q,
  output logic [3:0] clock_mode_register_q,
  output logic [3:0] clock_range_register_q,
  output logic [3:0] lcd_control_reg_one_q,
  output logic [3:0] lcd_control_reg_two_q,
  output logic [3:0] lcd_control_reg_three_q,
  output logic [3:0] lcd_config_reg_one_q,
  output logic [3:0] lcd_config_reg_two_q,
  output logic [2:0] op2_kind_q,
  output logic [9:0] op2_word_q,
  output logic op2_format_ok_q
);
  // ***************************************************************
  // Word split
  // ***************************************************************
  word_bus_if wb();
  assign wb.word = word_in;
  opdec_split u_split
  (
    .wb(wb)
  );

  // ***************************************************************
  // Sequencing state
  // ***************************************************************
  typedef enum logic [1:0]
  {
    S_FIRST = 2'b00,
    S_OPERAND = 2'b01,
    S_SKIP = 2'b11
  } seq_e;

  seq_e seq_q;
  seq_e seq_d;
  logic [2:0] kind_q;
  logic [2:0] kind_d;
  logic armed_q;
  logic armed_d;
  logic wdt_prep_q;
  logic wdt_prep_d;
  logic skip_next;
  logic is_exec;

  always_comb
  begin
    seq_d = seq_q;
    kind_d = kind_q;
    armed_d = armed_q;
    wdt_prep_d = wdt_prep_q;
    skip_next = 1'b0;
    is_exec = 1'b0;
    if (word_valid)
    begin
      case (seq_q)
        S_FIRST:
        begin
          is_exec = 1'b1;
          // Arming and disable-prep only reach the very next instruction
          armed_d = (word_in == opdec_pkg::OP_ARM_POWER_DOWN);
          wdt_prep_d = (word_in == opdec_pkg::OP_WATCHDOG_DISABLE_PREP);
          if ((word_in == opdec_pkg::OP_SKIP_ON_POWERDOWN_FLAG && powerdown_flag)
            || (word_in == opdec_pkg::OP_WATCHDOG_SERVICE && watchdog_flag_first))
          begin
            skip_next = 1'b1;
          end
          if (wb.two_kind != opdec_pkg::K_NONE)
          begin
            seq_d = S_OPERAND;
            kind_d = wb.two_kind;
          end
          else if (skip_next)
          begin
            seq_d = S_SKIP;
          end
        end
        S_OPERAND:
        begin
          seq_d = S_FIRST;
          kind_d = opdec_pkg::K_NONE;
        end
        S_SKIP:
        begin
          // Fetched, not executed; kind_q marks a skipped two-word operand still due
          armed_d = 1'b0;
          wdt_prep_d = 1'b0;
          if (kind_q == opdec_pkg::K_NONE && wb.two_kind != opdec_pkg::K_NONE)
          begin
            seq_d = S_SKIP;
            kind_d = wb.two_kind;
          end
          else
          begin
            seq_d = S_FIRST;
            kind_d = opdec_pkg::K_NONE;
          end
        end
        default: seq_d = S_FIRST;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      seq_q <= S_FIRST;
      kind_q <= opdec_pkg::K_NONE;
      armed_q <= 1'b0;
      wdt_prep_q <= 1'b0;
    end
    else
    begin
      seq_q <= seq_d;
      kind_q <= kind_d;
      armed_q <= armed_d;
      wdt_prep_q <= wdt_prep_d;
    end
  end

  // ***************************************************************
  // Execution effects
  // ***************************************************************
  logic exec_d;
  logic skipped_d;
  logic operand_d;
  logic sysrst_d;
  logic clkop_d;
  logic backup_d;
  logic wdclr_d;
  logic wdstop_d;
  logic hiref_d;
  logic vdet_d;
  logic rcsel_d;
  logic acc_load_d;
  logic [3:0] acc_d;
  logic [3:0] mode_d;
  logic [3:0] range_d;
  logic [3:0] l1_d;
  logic [3:0] l2_d;
  logic [3:0] l3_d;
  logic [3:0] c1_d;
  logic [3:0] c2_d;
  logic [2:0] op2k_d;
  logic [9:0] op2w_d;
  logic op2ok_d;

  always_comb
  begin
    exec_d = is_exec;
    skipped_d = word_valid && seq_q == S_SKIP;
    operand_d = word_valid && seq_q == S_OPERAND;
    sysrst_d = 1'b0;
    clkop_d = 1'b0;
    backup_d = 1'b0;
    wdclr_d = 1'b0;
    wdstop_d = watchdog_stop_q;
    hiref_d = high_ref_enable_flag_q;
    vdet_d = voltage_drop_detect_en_q;
    rcsel_d = rc_osc_selected_q;
    acc_load_d = 1'b0;
    acc_d = acc_out_q;
    mode_d = clock_mode_register_q;
    range_d = clock_range_register_q;
    l1_d = lcd_control_reg_one_q;
    l2_d = lcd_control_reg_two_q;
    l3_d = lcd_control_reg_three_q;
    c1_d = lcd_config_reg_one_q;
    c2_d = lcd_config_reg_two_q;
    op2k_d = op2_kind_q;
    op2w_d = op2_word_q;
    op2ok_d = op2_format_ok_q;
    // The all-zero word falls through every branch: the PC moves and arming and disable-prep lapse
    if (is_exec)
    begin
      // Every control instruction here completes in this one cycle
      case (word_in)
        opdec_pkg::OP_SOFTWARE_SYSTEM_RESET: sysrst_d = 1'b1;
        opdec_pkg::OP_ENTER_CLOCK_OPERATING: clkop_d = armed_q;
        opdec_pkg::OP_ENTER_RAM_BACKUP: backup_d = armed_q;
        opdec_pkg::OP_WATCHDOG_SERVICE:
        begin
          wdclr_d = watchdog_flag_first;
          if (wdt_prep_q)
          begin
            wdstop_d = 1'b1;
          end
        end
        opdec_pkg::OP_CLEAR_HIGH_REF: hiref_d = 1'b0;
        opdec_pkg::OP_SET_HIGH_REF: hiref_d = 1'b1;
        opdec_pkg::OP_ENABLE_VOLTAGE_DROP: vdet_d = HAS_VDET;
        opdec_pkg::OP_SELECT_RC_OSC: rcsel_d = 1'b1;
        opdec_pkg::OP_READ_CLOCK_MODE:
        begin
          acc_load_d = 1'b1;
          acc_d = clock_mode_register_q;
        end
        opdec_pkg::OP_WRITE_CLOCK_MODE: mode_d = acc_in;
        opdec_pkg::OP_WRITE_CLOCK_RANGE: range_d = acc_in;
        opdec_pkg::OP_READ_LCD_CTRL_ONE:
        begin
          acc_load_d = 1'b1;
          acc_d = lcd_control_reg_one_q;
        end
        opdec_pkg::OP_WRITE_LCD_CTRL_ONE: l1_d = acc_in;
        opdec_pkg::OP_WRITE_LCD_CTRL_TWO: l2_d = acc_in;
        opdec_pkg::OP_WRITE_LCD_CTRL_THREE: l3_d = acc_in;
        opdec_pkg::OP_WRITE_LCD_CFG_ONE: c1_d = acc_in;
        opdec_pkg::OP_WRITE_LCD_CFG_TWO: c2_d = acc_in;
        default: acc_load_d = 1'b0;
      endcase
    end
    // Operand word is checked against the format of its first word
    if (operand_d)
    begin
      op2k_d = kind_q;
      op2w_d = word_in;
      case (kind_q)
        opdec_pkg::K_LONG_JUMP, opdec_pkg::K_LONG_CALL:
          op2ok_d = word_in[opdec_pkg::SW_TOP];
        opdec_pkg::K_IND_JUMP, opdec_pkg::K_IND_CALL:
          op2ok_d = word_in[opdec_pkg::SW_TOP]
            && word_in[5:4] == opdec_pkg::SW_IND_ZERO;
        opdec_pkg::K_SEA: op2ok_d = word_in[9:4] == opdec_pkg::SW_SEA_PREFIX;
        opdec_pkg::K_SZD: op2ok_d = word_in == opdec_pkg::SW_SZD_FIXED;
        default: op2ok_d = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      exec_q <= 1'b0;
      skipped_q <= 1'b0;
      operand_q <= 1'b0;
      pc_advance_q <= 1'b0;
      system_reset_q <= 1'b0;
      enter_clock_operating_mode_q <= 1'b0;
      enter_ram_backup_mode_q <= 1'b0;
      watchdog_flag_clear_q <= 1'b0;
      watchdog_stop_q <= 1'b0;
      high_ref_enable_flag_q <= 1'b0;
      voltage_drop_detect_en_q <= 1'b0;
      rc_osc_selected_q <= 1'b0;
      onchip_osc_stop_q <= 1'b0;
      acc_load_q <= 1'b0;
      acc_out_q <= opdec_pkg::NIB_RESET;
      clock_mode_register_q <= opdec_pkg::NIB_RESET;
      clock_range_register_q <= opdec_pkg::NIB_RESET;
      lcd_control_reg_one_q <= opdec_pkg::NIB_RESET;
      lcd_control_reg_two_q <= opdec_pkg::NIB_RESET;
      lcd_control_reg_three_q <= opdec_pkg::NIB_RESET;
      lcd_config_reg_one_q <= opdec_pkg::NIB_RESET;
      lcd_config_reg_two_q <= opdec_pkg::NIB_RESET;
      op2_kind_q <= opdec_pkg::K_NONE;
      op2_word_q <= 10'h000;
      op2_format_ok_q <= 1'b0;
    end
    else
    begin
      exec_q <= exec_d;
      skipped_q <= skipped_d;
      operand_q <= operand_d;
      pc_advance_q <= word_valid;
      system_reset_q <= sysrst_d;
      enter_clock_operating_mode_q <= clkop_d;
      enter_ram_backup_mode_q <= backup_d;
      watchdog_flag_clear_q <= wdclr_d;
      watchdog_stop_q <= wdstop_d;
      high_ref_enable_flag_q <= hiref_d;
      voltage_drop_detect_en_q <= vdet_d;
      rc_osc_selected_q <= rcsel_d;
      onchip_osc_stop_q <= rcsel_d;
      acc_load_q <= acc_load_d;
      acc_out_q <= acc_d;
      clock_mode_register_q <= mode_d;
      clock_range_register_q <= range_d;
      lcd_control_reg_one_q <= l1_d;
      lcd_control_reg_two_q <= l2_d;
      lcd_control_reg_three_q <= l3_d;
      lcd_config_reg_one_q <= c1_d;
      lcd_config_reg_two_q <= c2_d;
      op2_kind_q <= op2k_d;
      op2_word_q <= op2w_d;
      op2_format_ok_q <= op2ok_d;
    end
  end
endmodule

//--- opdec_core_sva.sv
// Concurrent checks on the decoder ports
`timescale 1ns/1ns
module opdec_core_sva
(
  input wire logic clk,
  input wire logic rst,
  input wire logic word_valid,
  input wire logic [9:0] word_in,
  input wire logic [3:0] acc_in,
  input wire logic powerdown_flag,
  input wire logic watchdog_flag_first,
  input wire logic exec_q,
  input wire logic skipped_q,
  input wire logic pc_advance_q,
  input wire logic system_reset_q,
  input wire logic enter_clock_operating_mode_q,
  input wire logic enter_ram_backup_mode_q,
  input wire logic watchdog_flag_clear_q,
  input wire logic watchdog_stop_q,
  input wire logic high_ref_enable_flag_q,
  input wire logic [3:0] clock_mode_register_q,
  input wire logic [3:0] lcd_control_reg_one_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Last valid word, so arming can be judged across idle gaps
  logic [9:0] prev_q;
  logic [9:0] prev_d;
  always_comb prev_d = word_valid ? word_in : prev_q;
  always_ff @(posedge clk) prev_q <= rst ? 10'h000 : prev_d;
  a_pc_advance_each: assert property (pc_advance_q == $past(word_valid && !rst))
    else $error("fetch pulse wrong");
  a_arm_clock_op: assert property (word_valid && word_in == 10'h05B ##1
    exec_q && word_valid && word_in == 10'h002 |=> enter_clock_operating_mode_q)
    else $error("armed clock mode missing");
  a_arm_ram_backup: assert property (word_valid && word_in == 10'h05B ##1
    exec_q && word_valid && word_in == 10'h008 |=> enter_ram_backup_mode_q)
    else $error("armed backup missing");
  a_unarmed_refused: assert property (word_valid && prev_q != 10'h05B &&
    (word_in == 10'h002 || word_in == 10'h008) |=> !enter_clock_operating_mode_q
    && !enter_ram_backup_mode_q)
    else $error("unarmed power down acted");
  a_skip_pd_flag: assert property (word_valid && word_in == 10'h003 && powerdown_flag
    ##1 exec_q && word_valid |=> skipped_q && !exec_q)
    else $error("power flag skip missing");
  a_wdt_flag_clear: assert property (word_valid && word_in == 10'h2A0 &&
    watchdog_flag_first |=> !exec_q || watchdog_flag_clear_q)
    else $error("watchdog flag not cleared");
  a_wdt_stop_pair: assert property (word_valid && word_in == 10'h29C ##1
    exec_q && word_valid && word_in == 10'h2A0 |=> watchdog_stop_q)
    else $error("watchdog not stopped");
  a_high_ref_flag: assert property (word_valid && word_in[9:1] == 9'h02C |=>
    !exec_q || high_ref_enable_flag_q == $past(word_in[0]))
    else $error("reference flag wrong");
  a_mode_write: assert property (word_valid && word_in == 10'h216 |=>
    !exec_q || clock_mode_register_q == $past(acc_in))
    else $error("mode register write wrong");
  a_soft_reset: assert property (word_valid && word_in == 10'h001 |=>
    !exec_q || system_reset_q)
    else $error("software reset missing");
  a_skip_quiet: assert property (skipped_q |-> $stable(lcd_control_reg_one_q) &&
    $stable(clock_mode_register_q) && !system_reset_q)
    else $error("skipped word had effect");
  a_nop_quiet: assert property (word_valid && word_in == 10'h000 |=> !exec_q ||
    $stable(high_ref_enable_flag_q) && $stable(lcd_control_reg_one_q))
    else $error("no-op changed state");
  c_clock_op: cover property (enter_clock_operating_mode_q);
  c_skipped: cover property (skipped_q);
  c_wdt_stop: cover property ($rose(watchdog_stop_q));
  c_skip_pair: cover property (skipped_q ##1 skipped_q);
endmodule
bind opdec_core opdec_core_sva sva (.clk(clk), .rst(rst), .word_valid(word_valid),
  .word_in(word_in), .acc_in(acc_in), .powerdown_flag(powerdown_flag),
  .watchdog_flag_first(watchdog_flag_first), .exec_q(exec_q), .skipped_q(skipped_q),
  .pc_advance_q(pc_advance_q), .system_reset_q(system_reset_q),
  .enter_clock_operating_mode_q(enter_clock_operating_mode_q),
  .enter_ram_backup_mode_q(enter_ram_backup_mode_q),
  .watchdog_flag_clear_q(watchdog_flag_clear_q), .watchdog_stop_q(watchdog_stop_q),
  .high_ref_enable_flag_q(high_ref_enable_flag_q),
  .clock_mode_register_q(clock_mode_register_q),
  .lcd_control_reg_one_q(lcd_control_reg_one_q));

//--- prog_mem.sv
// Program memory model streaming instruction words
`timescale 1ns/1ns
module prog_mem
(
  input wire logic clk,
  input wire logic run,
  input wire logic stall,
  output logic word_valid,
  output logic [9:0] word_in,
  output logic done
);
  logic [9:0] rom [2048];
  int len = 0;
  int ptr = 0;
  initial word_valid = 1'b0;
  initial word_in = 10'h155;
  assign done = ptr >= len;
  always @(negedge clk)
  begin
    if (run && !stall && ptr < len)
    begin
      word_valid <= 1'b1;
      word_in <= rom[ptr];
      ptr <= ptr + 1;
    end
    else
    begin
      word_valid <= 1'b0;
      // Idle bus toggles so no stale word can pass for a fetch
      word_in <= ~word_in;
      if (!run)
        ptr <= 0;
    end
  end
endmodule

//--- nibble_cpu_opcode_decoder_tb_top.sv
// Random and directed bench with a reference model of the decoder
`timescale 1ns/1ns
module nibble_cpu_opcode_decoder_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic run = 1'b0;
  logic stall = 1'b0;
  logic rnd = 1'b0;
  logic [3:0] acc = 4'h0;
  logic pdf = 1'b0;
  logic wdf = 1'b0;
  logic word_valid, done;
  logic [9:0] word_in, ow, e_ow;
  wire [8:0] pul;
  wire [5:0] lev;
  logic [8:0] e_pul;
  logic [5:0] e_lev;
  logic [2:0] kd, e_k;
  wire [3:0] r [8];
  logic [3:0] er [8];
  logic [9:0] wc [7] = '{10'h216, 10'h209, 10'h20A, 10'h20B, 10'h20C, 10'h2A8, 10'h2A9};
  logic [9:0] sc [8] = '{10'h2A0, 10'h003, 10'h29C, 10'h000, 10'h05B, 10'h002, 10'h058, 10'h059};
  int pend, skip, arm, prep, cyc, n_fail, checks, seed;
  logic [9:0] q [$];
  always #20 clk = ~clk;
  prog_mem pm (.clk(clk), .run(run), .stall(stall), .word_valid(word_valid),
    .word_in(word_in), .done(done));
  opdec_core dut (.clk(clk), .rst(rst), .word_valid(word_valid), .word_in(word_in),
    .acc_in(acc), .powerdown_flag(pdf), .watchdog_flag_first(wdf), .exec_q(pul[0]),
    .skipped_q(pul[1]), .operand_q(pul[2]), .pc_advance_q(pul[3]),
    .system_reset_q(pul[4]), .enter_clock_operating_mode_q(pul[5]),
    .enter_ram_backup_mode_q(pul[6]), .watchdog_flag_clear_q(pul[7]), .acc_load_q(pul[8]),
    .watchdog_stop_q(lev[0]), .high_ref_enable_flag_q(lev[1]),
    .voltage_drop_detect_en_q(lev[2]), .rc_osc_selected_q(lev[3]),
    .onchip_osc_stop_q(lev[4]), .op2_format_ok_q(lev[5]), .acc_out_q(r[0]),
    .clock_mode_register_q(r[1]), .clock_range_register_q(r[2]),
    .lcd_control_reg_one_q(r[3]), .lcd_control_reg_two_q(r[4]),
    .lcd_control_reg_three_q(r[5]), .lcd_config_reg_one_q(r[6]),
    .lcd_config_reg_two_q(r[7]), .op2_kind_q(kd), .op2_word_q(ow));
  // ********************
  // Reference model
  // ********************
  function automatic int kind(input logic [9:0] w);
    if (w[9:5] == 5'h06)
      return 2;
    if (w[9:5] == 5'h07)
      return 1;
    return w == 10'h010 ? 3 : w == 10'h030 ? 4 : w == 10'h025 ? 5 : w == 10'h024 ? 6 : 0;
  endfunction
  function automatic logic fmt(input int k, input logic [9:0] w);
    case (k)
      1, 2: return w[9];
      3, 4: return w[9] && w[5:4] == 2'h0;
      5: return w[9:4] == 6'h07;
      default: return w == 10'h02B;
    endcase
  endfunction
  task automatic step(input logic [9:0] w);
    int a;
    int p;
    e_pul[3] = 1'b1;
    if (pend != 0)
    begin
      e_pul[2] = 1'b1;
      e_k = pend[2:0];
      e_ow = w;
      e_lev[5] = fmt(pend, w);
      pend = 0;
    end
    else if (skip != 0)
    begin
      e_pul[1] = 1'b1;
      // A skipped two-word instruction takes its operand word with it
      skip = (skip == 1 && kind(w) != 0) ? 2 : 0;
    end
    else
    begin
      e_pul[0] = 1'b1;
      a = arm;
      p = prep;
      arm = 0;
      prep = 0;
      for (int i = 0; i < 7; i++)
        if (w == wc[i])
          er[i + 1] = acc;
      case (w)
        10'h001: e_pul[4] = 1'b1;
        10'h002: e_pul[5] = a[0];
        10'h008: e_pul[6] = a[0];
        10'h003: skip = pdf;
        10'h05B: arm = 1;
        10'h29C: prep = 1;
        10'h2A0:
        begin
          skip = wdf;
          e_pul[7] = wdf;
          e_lev[0] = e_lev[0] | p[0];
        end
        10'h058, 10'h059: e_lev[1] = w[0];
        10'h293: e_lev[2] = 1'b1;
        10'h29B: e_lev[4:3] = 2'h3;
        10'h24A, 10'h252:
        begin
          e_pul[8] = 1'b1;
          er[0] = w[3] ? er[3] : er[1];
        end
        10'h000, 10'h209, 10'h20A, 10'h20B, 10'h20C, 10'h216, 10'h2A8, 10'h2A9: ;
        default: pend = kind(w);
      endcase
    end
  endtask
  always @(posedge clk)
  begin
    e_pul = '0;
    if (rst)
    begin
      {e_lev, e_k, e_ow, pend, skip, arm, prep} = '0;
      foreach (er[i]) er[i] = 4'h0;
    end
    else if (word_valid)
      step(word_in);
    cyc++;
    if (cyc == 6000)
    begin
      n_fail++;
      complete_run();
    end
  end
  // ********************
  // Checks and stimulus
  // ********************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  always @(negedge clk)
  begin
    chk({kd, ow, lev, pul}, {e_k, e_ow, e_lev, e_pul});
    foreach (r[i]) chk(r[i], er[i]);
    acc <= 4'($urandom);
    pdf <= 1'($urandom);
    wdf <= 1'($urandom);
    stall <= rnd && $urandom_range(3) == 0;
  end
  task automatic play(input logic [9:0] p [$]);
    foreach (p[i]) pm.rom[i] = p[i];
    pm.len = p.size();
    run <= 1'b1;
    repeat (2) @(negedge clk);
    while (!done) @(negedge clk);
    repeat (2) @(negedge clk);
    run <= 1'b0;
    @(negedge clk);
  endtask
  task automatic complete_run();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    seed = $urandom(32'hDCC9);
    repeat (2) @(negedge clk);
    rst = 1'b0;
    play('{10'h001});
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    play('{10'h05B, 10'h002, 10'h05B, 10'h008, 10'h002, 10'h008, 10'h05B, 10'h000, 10'h002,
      10'h29C, 10'h2A0, 10'h2A0, 10'h20A, 10'h003, 10'h0E0, 10'h3FF, 10'h003, 10'h20A,
      10'h0E0, 10'h0FF, 10'h0C0,
      10'h200, 10'h0F0, 10'h3FF, 10'h010, 10'h330, 10'h030, 10'h2CF, 10'h025, 10'h07A,
      10'h024, 10'h02B, 10'h059, 10'h058, 10'h059, 10'h293, 10'h29B, 10'h20A, 10'h24A,
      10'h216, 10'h252, 10'h209, 10'h20B, 10'h20C, 10'h2A8, 10'h2A9, 10'h000});
    // Assigned codes drawn from the tables wc and sc, plus the long jumps added below
    wc = '{10'h216, 10'h209, 10'h20A, 10'h20B, 10'h20C, 10'h2A8, 10'h2A9};
    for (int i = 0; i < 1500; i++)
    begin
      q.push_back(i % 3 == 0 ? wc[$urandom_range(6)] : sc[$urandom_range(7)]);
      // A long jump with any operand, so skips over two-word instructions occur
      if (i % 16 == 5)
      begin
        q.push_back(10'h0E0);
        q.push_back(10'($urandom));
      end
    end
    rnd = 1'b1;
    play(q);
    complete_run();
  end
endmodule
